// ==== sdpc_cmd_enc.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_regs.svh"

module sdpc_cmd_enc (
  sdpc_cmd_if.enc cmd_bus
);

  logic [2:0] enc;

  always_comb begin
    case (cmd_bus.cmd)
      sdpc_pkg::SDPC_CMD_ACT: enc = `SDPC_ENC_ACT;
      sdpc_pkg::SDPC_CMD_READ: enc = `SDPC_ENC_READ;
      sdpc_pkg::SDPC_CMD_WRITE: enc = `SDPC_ENC_WRITE;
      sdpc_pkg::SDPC_CMD_PRE: enc = `SDPC_ENC_PRE;
      sdpc_pkg::SDPC_CMD_REF: enc = `SDPC_ENC_REF;
      sdpc_pkg::SDPC_CMD_MRS: enc = `SDPC_ENC_MRS;
      default: enc = `SDPC_ENC_NOP;
    endcase
  end

  assign cmd_bus.ras_n = enc[2];
  assign cmd_bus.cas_n = enc[1];
  assign cmd_bus.we_n = enc[0];

endmodule : sdpc_cmd_enc

`default_nettype wire

// ==== sdpc_cmd_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface sdpc_cmd_if;
  sdpc_pkg::sdpc_cmd_t cmd;
  logic ras_n;
  logic cas_n;
  logic we_n;
  modport ctl (output cmd, input ras_n, input cas_n, input we_n);
  modport enc (input cmd, output ras_n, output cas_n, output we_n);
endinterface : sdpc_cmd_if

`default_nettype wire

// ==== sdpc_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module sdpc_mem_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_pins,
  input wire logic i_lmask,
  input wire logic i_hmask,
  output logic o_lo_z,
  output logic o_hi_z
);
  // Masks matter only in a selected column cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lo_z <= 1'b0;
      o_hi_z <= 1'b0;
    end else if (i_pins[3:1] == 3'b010) begin
      o_lo_z <= i_lmask;
      o_hi_z <= i_hmask;
    end
  end
endmodule : sdpc_mem_model

`default_nettype wire

// ==== sdpc_pkg.sv ====
package sdpc_pkg;

  typedef enum logic [2:0] {
    SDPC_CMD_NOP,
    SDPC_CMD_ACT,
    SDPC_CMD_READ,
    SDPC_CMD_WRITE,
    SDPC_CMD_PRE,
    SDPC_CMD_REF,
    SDPC_CMD_MRS
  } sdpc_cmd_t;

endpackage : sdpc_pkg

// ==== sdpc_regs.svh ====
`ifndef SDPC_REGS_SVH
`define SDPC_REGS_SVH

// Upper address field that selects the SDRAM region
`define SDPC_REGION_HI 31
`define SDPC_REGION_LO 26
`define SDPC_REGION_PAT 6'h01

// Dedicated address bit carried on its own pin
`define SDPC_A10_BIT 10

// Command pin patterns {row strobe, column strobe, write enable}, all active low
`define SDPC_ENC_NOP 3'h7
`define SDPC_ENC_ACT 3'h3
`define SDPC_ENC_READ 3'h5
`define SDPC_ENC_WRITE 3'h4
`define SDPC_ENC_PRE 3'h2
`define SDPC_ENC_REF 3'h1
`define SDPC_ENC_MRS 3'h0

// Timing
`define SDPC_CLK_PERIOD_NS 100
`define SDPC_TRCD_NS 20
`define SDPC_TRP_NS 20

`endif

// ==== sdpc_top.sv ====
// Notes on behaviour
// - The region select goes low for every command cycle of an access whose top six address bits match the SDRAM region.
// - Only the bus master drives the region select; a slave leaves it undriven.
// - The row strobe is low in the cycle that carries the row address of a read or write.
// - The column strobe is low in the cycle that carries the column address of a read or write.
// - With the column strobe low, write enable is low for a write and high for a read.
// - Other operations use the standard SDRAM pattern on row strobe, column strobe and write enable.
// - Both data masks are inactive outside column cycles and during reads.
// - A write to an odd single word on a 64-bit bus raises the low-word mask.
// - A write to an even single word, or any write on a 32-bit bus, raises the high-word mask.
// - Address bit ten leaves on its own pin, apart from the shared address bus.
// - Clock enable takes the memory into and out of self-refresh and suspend.
// - The master weakly holds clock enable high before the grant, or low when in self-refresh; a slave holds nothing.
// - To grant the bus to a host the master floats all memory control pins in the cycle its self-refresh entry reaches them, so that entry is never driven.
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_regs.svh"

module sdpc_top #(
  parameter int ROW_W = 12,
  parameter int COL_W = 8,
  parameter int TRCD_NS = `SDPC_TRCD_NS,
  parameter int TRP_NS = `SDPC_TRP_NS
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_IS_MASTER,
  input wire logic I_BUS_32,
  input wire logic I_HOST_BUS_REQUEST_N,
  input wire logic I_REQ_VALID,
  input wire logic I_REQ_WRITE,
  input wire logic I_REQ_LONG,
  input wire logic [31:0] I_REQ_ADDR,
  output logic O_REQ_READY,
  input wire logic I_REFRESH_REQ,
  output logic O_REFRESH_ACK,
  input wire logic I_MODE_REQ,
  input wire logic [ROW_W-1:0] I_MODE_VALUE,
  output logic O_MODE_ACK,
  input wire logic I_SREF_REQ,
  input wire logic I_SUSPEND_REQ,
  output logic O_IN_SREF,
  output logic O_IN_SUSPEND,
  output logic O_SDRAM_SPACE_SELECT_N,
  output logic O_RAS_N,
  output logic O_CAS_N,
  output logic O_SDRAM_WRITE_ENABLE_N,
  output logic O_LOW_WORD_DATA_MASK,
  output logic O_HIGH_WORD_DATA_MASK,
  output logic [ROW_W-1:0] O_SDRAM_ADDR,
  output logic O_SDRAM_ADDR_BIT_TEN,
  output logic O_SDRAM_CLOCK_ENABLE,
  output logic O_SDRAM_PINS_OE,
  output logic O_SDRAM_CLOCK_ENABLE_KEEP_EN,
  output logic O_SDRAM_CLOCK_ENABLE_KEEP_LVL,
  output logic O_HOST_BUS_GRANT_N,
  output logic O_HOST_BUS_GRANT_OE
);

  localparam int TRCD_RAW = (TRCD_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS;
  localparam int TRP_RAW = (TRP_NS + `SDPC_CLK_PERIOD_NS - 1) / `SDPC_CLK_PERIOD_NS;
  localparam logic [3:0] TRCD_CYC = (TRCD_RAW < 1) ? 4'h1 : 4'(TRCD_RAW);
  localparam logic [3:0] TRP_CYC = (TRP_RAW < 1) ? 4'h1 : 4'(TRP_RAW);

  typedef enum {
    ST_IDLE, ST_ACT, ST_RCD, ST_RW, ST_PRE, ST_RP, ST_REF, ST_MRS,
    ST_SREF_IN, ST_SREF, ST_HOST, ST_PDN, ST_WAKE
  } sdpc_state_t;

  sdpc_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic hbr_s1_q, hbr_s2_q;
  logic [31:0] addr_q;
  logic write_q, long_q, bus32_q;
  logic cs_n_q, cs_n_d;
  logic ras_n_q, cas_n_q, we_n_q;
  logic lmask_q, lmask_d, hmask_q, hmask_d;
  logic [ROW_W-1:0] pin_addr_q, pin_addr_d;
  logic a10_q, a10_d;
  logic cke_q, cke_d;
  logic hbg_n_q;
  logic host_req, in_region, accept, granted, in_sref;
  logic [ROW_W-1:0] row, col;

  sdpc_cmd_if cmd_bus ();

  sdpc_cmd_enc u_enc (
    .cmd_bus(cmd_bus)
  );

  // Host request pin arrives asynchronously
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hbr_s1_q <= 1'b1;
      hbr_s2_q <= 1'b1;
    end else begin
      hbr_s1_q <= I_HOST_BUS_REQUEST_N;
      hbr_s2_q <= hbr_s1_q;
    end
  end

  assign host_req = I_IS_MASTER && !hbr_s2_q;
  assign in_region = I_REQ_ADDR[`SDPC_REGION_HI:`SDPC_REGION_LO] == `SDPC_REGION_PAT;
  assign granted = state_q == ST_HOST;
  assign in_sref = (state_q == ST_SREF_IN) || (state_q == ST_SREF) || granted;

  // Higher-priority work blocks new accesses
  assign O_REQ_READY = (state_q == ST_IDLE) && I_IS_MASTER && !host_req && !I_SREF_REQ
                       && !I_SUSPEND_REQ && !I_REFRESH_REQ && !I_MODE_REQ;
  assign accept = O_REQ_READY && I_REQ_VALID;
  assign O_REFRESH_ACK = state_q == ST_REF;
  assign O_MODE_ACK = state_q == ST_MRS;
  assign O_IN_SREF = in_sref;
  assign O_IN_SUSPEND = state_q == ST_PDN;

  // Column indexes 64-bit words unless the bus is 32 bits wide
  always_comb begin
    if (bus32_q) begin
      row = ROW_W'(addr_q[COL_W+ROW_W-1:COL_W]);
      col = ROW_W'(addr_q[COL_W-1:0]);
    end else begin
      row = ROW_W'(addr_q[COL_W+ROW_W:COL_W+1]);
      col = ROW_W'(addr_q[COL_W:1]);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      addr_q <= 32'h0;
      write_q <= 1'b0;
      long_q <= 1'b0;
      bus32_q <= 1'b0;
    end else if (accept) begin
      addr_q <= I_REQ_ADDR;
      write_q <= I_REQ_WRITE;
      long_q <= I_REQ_LONG;
      bus32_q <= I_BUS_32;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_bus.cmd = sdpc_pkg::SDPC_CMD_NOP;
    pin_addr_d = pin_addr_q;
    a10_d = 1'b0;
    lmask_d = 1'b0;
    hmask_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (host_req) begin
          state_d = ST_SREF_IN;
        end else if (I_SREF_REQ && I_IS_MASTER) begin
          state_d = ST_SREF_IN;
        end else if (I_SUSPEND_REQ && I_IS_MASTER) begin
          state_d = ST_PDN;
        end else if (I_REFRESH_REQ && I_IS_MASTER) begin
          state_d = ST_REF;
        end else if (I_MODE_REQ && I_IS_MASTER) begin
          state_d = ST_MRS;
        end else if (accept && in_region) begin
          state_d = ST_ACT;
        end
      end
      ST_ACT: begin
        cmd_bus.cmd = sdpc_pkg::SDPC_CMD_ACT;
        pin_addr_d = row;
        a10_d = row[`SDPC_A10_BIT];
        cnt_d = TRCD_CYC - 4'h1;
        state_d = ST_RCD;
      end
      ST_RCD: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_RW;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_RW: begin
        // No auto-precharge: bit ten stays low in column cycles
        cmd_bus.cmd = write_q ? sdpc_pkg::SDPC_CMD_WRITE : sdpc_pkg::SDPC_CMD_READ;
        pin_addr_d = col;
        lmask_d = write_q && !bus32_q && !long_q && addr_q[0];
        hmask_d = write_q && (bus32_q || (!long_q && !addr_q[0]));
        state_d = ST_PRE;
      end
      ST_PRE: begin
        // Closing after every access keeps all banks idle for refresh
        cmd_bus.cmd = sdpc_pkg::SDPC_CMD_PRE;
        a10_d = 1'b1;
        cnt_d = TRP_CYC - 4'h1;
        state_d = ST_RP;
      end
      ST_RP: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_REF: begin
        cmd_bus.cmd = sdpc_pkg::SDPC_CMD_REF;
        cnt_d = TRP_CYC - 4'h1;
        state_d = ST_RP;
      end
      ST_MRS: begin
        cmd_bus.cmd = sdpc_pkg::SDPC_CMD_MRS;
        pin_addr_d = I_MODE_VALUE;
        a10_d = I_MODE_VALUE[`SDPC_A10_BIT];
        state_d = ST_RP;
        cnt_d = TRP_CYC - 4'h1;
      end
      ST_SREF_IN: begin
        cmd_bus.cmd = sdpc_pkg::SDPC_CMD_REF;
        state_d = host_req ? ST_HOST : ST_SREF;
      end
      ST_SREF: begin
        if (host_req) begin
          state_d = ST_HOST;
        end else if (!I_SREF_REQ) begin
          state_d = ST_WAKE;
        end
      end
      ST_HOST: begin
        if (!host_req) begin
          state_d = I_SREF_REQ ? ST_SREF : ST_WAKE;
        end
      end
      ST_PDN: begin
        if (!I_SUSPEND_REQ || host_req) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        cnt_d = TRP_CYC - 4'h1;
        state_d = ST_RP;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  assign cs_n_d = cmd_bus.cmd == sdpc_pkg::SDPC_CMD_NOP;
  // Low in the cycle that issues self-refresh entry, high again on wake
  assign cke_d = !((state_q == ST_SREF_IN) || (state_q == ST_SREF) || granted
                   || (state_q == ST_PDN));

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cs_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      lmask_q <= 1'b0;
      hmask_q <= 1'b0;
      pin_addr_q <= '0;
      a10_q <= 1'b0;
      cke_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n_d;
      ras_n_q <= cmd_bus.ras_n;
      cas_n_q <= cmd_bus.cas_n;
      we_n_q <= cmd_bus.we_n;
      lmask_q <= lmask_d;
      hmask_q <= hmask_d;
      pin_addr_q <= pin_addr_d;
      a10_q <= a10_d;
      cke_q <= cke_d;
    end
  end

  // Grant lags the pin release by one cycle so the host never overlaps us
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hbg_n_q <= 1'b1;
    end else begin
      hbg_n_q <= !granted;
    end
  end

  assign O_SDRAM_SPACE_SELECT_N = cs_n_q;
  assign O_RAS_N = ras_n_q;
  assign O_CAS_N = cas_n_q;
  assign O_SDRAM_WRITE_ENABLE_N = we_n_q;
  assign O_LOW_WORD_DATA_MASK = lmask_q;
  assign O_HIGH_WORD_DATA_MASK = hmask_q;
  assign O_SDRAM_ADDR = pin_addr_q;
  assign O_SDRAM_ADDR_BIT_TEN = a10_q;
  assign O_SDRAM_CLOCK_ENABLE = cke_q;
  // Pins stay floated until the grant has been withdrawn at the pin
  assign O_SDRAM_PINS_OE = I_IS_MASTER && !granted && hbg_n_q;
  assign O_SDRAM_CLOCK_ENABLE_KEEP_EN = I_IS_MASTER && !granted && hbg_n_q;
  assign O_SDRAM_CLOCK_ENABLE_KEEP_LVL = !in_sref;
  assign O_HOST_BUS_GRANT_N = hbg_n_q;
  assign O_HOST_BUS_GRANT_OE = I_IS_MASTER;

endmodule : sdpc_top

`default_nettype wire

// ==== sdpc_top_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_regs.svh"

module sdpc_top_checker (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_IS_MASTER,
  input wire logic O_SDRAM_SPACE_SELECT_N,
  input wire logic O_RAS_N,
  input wire logic O_CAS_N,
  input wire logic O_SDRAM_WRITE_ENABLE_N,
  input wire logic O_LOW_WORD_DATA_MASK,
  input wire logic O_HIGH_WORD_DATA_MASK,
  input wire logic O_SDRAM_ADDR_BIT_TEN,
  input wire logic O_SDRAM_CLOCK_ENABLE,
  input wire logic O_SDRAM_PINS_OE,
  input wire logic O_SDRAM_CLOCK_ENABLE_KEEP_EN,
  input wire logic O_IN_SREF,
  input wire logic O_HOST_BUS_GRANT_N
);
  wire logic [2:0] c = {O_RAS_N, O_CAS_N, O_SDRAM_WRITE_ENABLE_N};
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  chk_sel_cmd: assert property (!O_SDRAM_SPACE_SELECT_N == (c != `SDPC_ENC_NOP))
    else $error("select does not match command");
  chk_act_seq: assert property (c == `SDPC_ENC_ACT |=>
    c == `SDPC_ENC_NOP ##1 c[2:1] == 2'b10 ##1 c == `SDPC_ENC_PRE)
    else $error("activate not followed by column then precharge");
  chk_mask_col: assert property (O_LOW_WORD_DATA_MASK || O_HIGH_WORD_DATA_MASK |->
    c == `SDPC_ENC_WRITE) else $error("mask outside write column");
  chk_pre_bit_ten: assert property (c == `SDPC_ENC_PRE |-> O_SDRAM_ADDR_BIT_TEN)
    else $error("precharge without all banks");
  chk_col_bit_ten: assert property (c[2:1] == 2'b10 |-> !O_SDRAM_ADDR_BIT_TEN)
    else $error("bit ten set in column cycle");
  chk_sref_cke: assert property (O_IN_SREF && $past(O_IN_SREF) |-> !O_SDRAM_CLOCK_ENABLE)
    else $error("clock enable high in self refresh");
  chk_grant_float: assert property (!O_HOST_BUS_GRANT_N |->
    !O_SDRAM_PINS_OE && !O_SDRAM_CLOCK_ENABLE) else $error("pins driven while granted");
  chk_slave_float: assert property (!I_IS_MASTER |->
    !O_SDRAM_PINS_OE && !O_SDRAM_CLOCK_ENABLE_KEEP_EN) else $error("slave drives pins");
endmodule : sdpc_top_checker

bind sdpc_top sdpc_top_checker sdpc_top_checker_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_IS_MASTER(I_IS_MASTER), .O_SDRAM_SPACE_SELECT_N(O_SDRAM_SPACE_SELECT_N),
  .O_RAS_N(O_RAS_N), .O_CAS_N(O_CAS_N), .O_SDRAM_WRITE_ENABLE_N(O_SDRAM_WRITE_ENABLE_N),
  .O_LOW_WORD_DATA_MASK(O_LOW_WORD_DATA_MASK), .O_HIGH_WORD_DATA_MASK(O_HIGH_WORD_DATA_MASK),
  .O_SDRAM_ADDR_BIT_TEN(O_SDRAM_ADDR_BIT_TEN), .O_SDRAM_CLOCK_ENABLE(O_SDRAM_CLOCK_ENABLE),
  .O_SDRAM_PINS_OE(O_SDRAM_PINS_OE), .O_SDRAM_CLOCK_ENABLE_KEEP_EN(O_SDRAM_CLOCK_ENABLE_KEEP_EN),
  .O_IN_SREF(O_IN_SREF), .O_HOST_BUS_GRANT_N(O_HOST_BUS_GRANT_N));

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sdpc_regs.svh"

module tb_top;
  logic clk = 0, rst = 1, ms = 1, b32 = 0, hrq = 1, vl = 0, wr = 0, lg = 0;
  logic rf = 0, md = 0, sr = 0, sp = 0;
  logic [31:0] ad = 32'h0, seed = 32'h40, r;
  logic [11:0] mv = 12'h0, sa, row, col;
  logic rdy, rfa, mda, isr, isp, sel, ras, cas, we, lm, hm, a10, ck, oe, ken, klv, gn, goe;
  logic lz, hz, ra10, ml, mh;
  logic [7:0] cs;
  int err_count = 0, cmp_count = 0;

  sdpc_top sdpc_top_i (.I_CLK(clk), .I_RST(rst), .I_IS_MASTER(ms), .I_BUS_32(b32),
    .I_HOST_BUS_REQUEST_N(hrq), .I_REQ_VALID(vl), .I_REQ_WRITE(wr), .I_REQ_LONG(lg),
    .I_REQ_ADDR(ad), .O_REQ_READY(rdy), .I_REFRESH_REQ(rf), .O_REFRESH_ACK(rfa),
    .I_MODE_REQ(md), .I_MODE_VALUE(mv), .O_MODE_ACK(mda), .I_SREF_REQ(sr),
    .I_SUSPEND_REQ(sp), .O_IN_SREF(isr), .O_IN_SUSPEND(isp), .O_SDRAM_SPACE_SELECT_N(sel),
    .O_RAS_N(ras), .O_CAS_N(cas), .O_SDRAM_WRITE_ENABLE_N(we), .O_LOW_WORD_DATA_MASK(lm),
    .O_HIGH_WORD_DATA_MASK(hm), .O_SDRAM_ADDR(sa), .O_SDRAM_ADDR_BIT_TEN(a10),
    .O_SDRAM_CLOCK_ENABLE(ck), .O_SDRAM_PINS_OE(oe), .O_SDRAM_CLOCK_ENABLE_KEEP_EN(ken),
    .O_SDRAM_CLOCK_ENABLE_KEEP_LVL(klv), .O_HOST_BUS_GRANT_N(gn), .O_HOST_BUS_GRANT_OE(goe));
  sdpc_mem_model sdpc_mem_model_i (.i_clk(clk), .i_rst(rst), .i_pins({sel, ras, cas, we}),
    .i_lmask(lm), .i_hmask(hm), .o_lo_z(lz), .o_hi_z(hz));

  initial forever #50 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : check

  // Records which commands were issued and what the key cycles carried
  task automatic scan(input int n);
    cs = 8'h00;
    repeat (n) begin
      @(negedge clk);
      if (!sel) cs[{ras, cas, we}] = 1'b1;
      if ({ras, cas, we} == `SDPC_ENC_ACT) {row, ra10} = {sa, a10};
      if ({ras, cas} == 2'b10) {col, ml, mh} = {sa, lm, hm};
      if ({ras, cas, we} == `SDPC_ENC_MRS) col = sa;
    end
  endtask : scan

  task automatic access(input logic w, l, b, input logic [31:0] a);
    int k = 0;
    @(posedge clk);
    {vl, wr, lg, b32, ad} <= {1'b1, w, l, b, a};
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 40);
    vl <= 1'b0;
    scan(8);
    if (a[31:26] != 6'h01) check(cs, 8'h00);
    else begin
      check(cs, 8'h0C | (w ? 8'h10 : 8'h20));
      check(row, b ? a[19:8] : a[20:9]);
      check(ra10, b ? a[18] : a[19]);
      check(col, b ? {4'h0, a[7:0]} : {4'h0, a[8:1]});
      check({ml, lz}, {2{w & ~b & ~l & a[0]}});
      check({mh, hz}, {2{w & (b | (~l & ~a[0]))}});
    end
  endtask : access

  task automatic side(input logic m);
    int k = 0;
    @(posedge clk);
    if (m) md <= 1'b1;
    else rf <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while ((m ? mda : rfa) !== 1'b1 && k < 40);
    {rf, md} <= 2'b00;
    scan(4);
    check(cs, m ? 8'h01 : 8'h02);
    if (m) check(col, mv);
  endtask : side

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    access(1, 0, 0, 32'h0408_0A46);
    access(1, 0, 0, 32'h0408_0A47);
    access(1, 1, 0, 32'h0400_1234);
    access(0, 0, 0, 32'h0400_0A47);
    access(1, 0, 1, 32'h0404_0A47);
    access(1, 0, 0, 32'h0800_0A46);
    repeat (20) begin
      r = rnd();
      access(r[0], r[1], r[3], {r[2] ? 6'h01 : r[31:26], r[25:0]});
    end
    $display("access tests done");
    side(0);
    mv <= 12'(rnd());
    side(1);
    $display("refresh and mode tests done");
    @(posedge clk) sr <= 1'b1;
    scan(6);
    check({cs, ck, klv, isr}, {8'h02, 3'b001});
    @(posedge clk) sr <= 1'b0;
    scan(6);
    check({ck, klv}, 2'b11);
    @(posedge clk) sp <= 1'b1;
    scan(4);
    check({cs, ck, isp}, {8'h00, 2'b01});
    @(posedge clk) sp <= 1'b0;
    scan(6);
    check(ck, 1'b1);
    $display("power tests done");
    @(posedge clk) hrq <= 1'b0;
    scan(10);
    check({gn, oe, ck, ken}, 4'h0);
    @(posedge clk) hrq <= 1'b1;
    scan(8);
    check({gn, oe, ck, ken}, 4'hF);
    @(posedge clk) ms <= 1'b0;
    scan(3);
    check({oe, ken, goe, rdy}, 4'h0);
    @(posedge clk) ms <= 1'b1;
    access(1, 0, 0, 32'h0400_0002);
    $display("host and slave tests done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
